// >>> hdl/flash_selfprog.sv
`timescale 1ns/100ps
//
// Overview of operation
// - erase pattern then store within four cycles
// - erase uses page field only
// - halting-section erase stalls the cpu
// - load pattern stores data pair into word
// - buffer cleared on write, reenable, reset
// - eeprom write discards partly loaded buffer
// - write pattern then store starts page write
// - halting-section write stalls the cpu
// - interrupt level while store enable clear
// - section busy blocks concurrent section reads
// - lock pattern then store sets lock bits
// - cleared data bits 5..2 program locks
// - eeprom busy refuses commands and fuse reads
// - lock byte read at pointer one, self-clear
// - fuse bytes read at pointers 0,3,2
// - programmed bits read zero, unprogrammed one
// - signature and calibration bytes read back
// - reset does not abort a running write
// - store enable self-clears, held during operation
// - other patterns have no effect
//
module flash_selfprog #(
    parameter int PROG_CYCLES = flash_selfprog_pkg::PROG_CYCLES,
    parameter logic [7:0] SIG_BYTE1 = 8'h5a, // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h3c, // arbitrary value
    parameter logic [7:0] SIG_BYTE3 = 8'h01 // arbitrary value
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hreadyin,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic eeprom_write_busy,
    input wire logic eeprom_write_start,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [7:0] extended_fuse_byte,
    input wire logic [7:0] osc_cal_byte,
    input wire logic [6:0] buf_rd_word,
    output logic [15:0] buf_rd_data,
    output logic flash_erase_start,
    output logic flash_write_start,
    output logic [7:0] flash_page,
    output logic section_busy_flag,
    output logic concurrent_read_block,
    output logic cpu_halt,
    output logic selfprog_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    localparam int PAGE_W = flash_selfprog_pkg::PAGE_WORDS;

    typedef struct packed {
        logic [7:0] ctl;
        logic [2:0] win;
        logic [15:0] ptr;
        logic [15:0] data;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic rd_done;
        logic [31:0] rdata;
        logic rst_pending;
    } sys_s;

    typedef struct packed {
        flash_selfprog_pkg::op_e state;
        logic [19:0] cnt;
        logic [7:0] page;
        logic [5:0] lock_data;
        logic [5:0] lock;
        logic [PAGE_W-1:0] valid;
        logic erase_p;
        logic write_p;
    } op_s;

    sys_s s_r;
    sys_s s_nxt;
    op_s o_r;
    op_s o_nxt;
    logic [15:0] buf_mem [0:PAGE_W-1];
    logic buf_we;
    logic [6:0] buf_wa;
    logic op_done;
    logic armed;
    logic ctrl_wr;
    logic store_wr;
    logic store_ok;
    logic load_rd;
    logic [7:0] wbyte;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // accepted command byte, signature read included
    function automatic logic is_cmd(input logic [7:0] v);
        logic ok;
        ok = 1'b0;
        if (v[flash_selfprog_pkg::BIT_SIGNATURE_READ_SELECT]) begin
            ok = (v[4:0] == flash_selfprog_pkg::CMD_LOAD);
        end else begin
            case (v[4:0])
                flash_selfprog_pkg::CMD_LOAD,
                flash_selfprog_pkg::CMD_ERASE,
                flash_selfprog_pkg::CMD_WRITE,
                flash_selfprog_pkg::CMD_LOCK,
                flash_selfprog_pkg::CMD_REEN: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // page lies in the halting section
    function automatic logic in_halt(input logic [7:0] pg);
        return pg >= flash_selfprog_pkg::HALT_FIRST_PAGE;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus and sequencer next state

    always_comb begin
        s_nxt = s_r;
        o_nxt = o_r;
        buf_we = 1'b0;
        buf_wa = s_r.ptr[7:1];
        o_nxt.erase_p = 1'b0;
        o_nxt.write_p = 1'b0;
        wbyte = hwdata[7:0];
        op_done = (o_r.state != flash_selfprog_pkg::OP_IDLE) && (o_r.cnt == 20'h1);
        armed = s_r.ctl[flash_selfprog_pkg::BIT_STORE_EN]
            && (o_r.state == flash_selfprog_pkg::OP_IDLE);
        ctrl_wr = s_r.ap_valid && s_r.ap_write && (s_r.ap_addr == flash_selfprog_pkg::ADDR_CTRL);
        store_wr = s_r.ap_valid && s_r.ap_write
            && (s_r.ap_addr == flash_selfprog_pkg::ADDR_STORE);
        store_ok = store_wr && armed && (s_r.win < flash_selfprog_pkg::STORE_WINDOW)
            && !eeprom_write_busy;
        load_rd = s_r.ap_valid && !s_r.ap_write && !s_r.rd_done
            && (s_r.ap_addr == flash_selfprog_pkg::ADDR_LOAD);

        // address phase capture, one wait state on reads
        if (hreadyout) begin
            s_nxt.ap_valid = hsel && htrans[1] && hreadyin;
            s_nxt.ap_write = hwrite;
            s_nxt.ap_addr = haddr[7:0];
            s_nxt.rd_done = 1'b0;
        end else begin
            s_nxt.rd_done = 1'b1;
        end

        // register reads, latched in the first data cycle
        if (s_r.ap_valid && !s_r.ap_write && !s_r.rd_done) begin
            case (s_r.ap_addr)
                flash_selfprog_pkg::ADDR_CTRL: s_nxt.rdata = {24'h0, s_r.ctl};
                flash_selfprog_pkg::ADDR_PTR: s_nxt.rdata = {16'h0, s_r.ptr};
                flash_selfprog_pkg::ADDR_DATA: s_nxt.rdata = {16'h0, s_r.data};
                default: s_nxt.rdata = 32'h0;
            endcase
        end

        // command window ageing
        if (armed) begin
            s_nxt.win = s_r.win + 3'h1;
            if (s_r.ctl[flash_selfprog_pkg::BIT_SIGNATURE_READ_SELECT]
                && s_r.win == flash_selfprog_pkg::LOAD_WINDOW - 3'h1) begin
                s_nxt.ctl[5:0] = 6'h0;
            end
            if (s_r.win == flash_selfprog_pkg::STORE_WINDOW - 3'h1) begin
                s_nxt.ctl[5:0] = 6'h0;
            end
        end

        // programming engine countdown
        if (o_r.state != flash_selfprog_pkg::OP_IDLE) begin
            o_nxt.cnt = o_r.cnt - 20'h1;
        end
        if (op_done) begin
            o_nxt.state = flash_selfprog_pkg::OP_IDLE;
            s_nxt.ctl[5:0] = 6'h0;
            if (o_r.state == flash_selfprog_pkg::OP_WRITE) begin
                o_nxt.valid = '0;
            end
            if (o_r.state == flash_selfprog_pkg::OP_LOCK) begin
                o_nxt.lock = o_r.lock & o_r.lock_data;
            end
        end

        // plain register writes
        if (s_r.ap_valid && s_r.ap_write && s_r.ap_addr == flash_selfprog_pkg::ADDR_PTR) begin
            s_nxt.ptr = hwdata[15:0];
        end
        if (s_r.ap_valid && s_r.ap_write && s_r.ap_addr == flash_selfprog_pkg::ADDR_DATA) begin
            s_nxt.data = hwdata[15:0];
        end

        // control write arms a command
        if (ctrl_wr) begin
            s_nxt.ctl[flash_selfprog_pkg::BIT_IE] = wbyte[flash_selfprog_pkg::BIT_IE];
            if (is_cmd(wbyte) && !armed && !eeprom_write_busy
                && o_r.state == flash_selfprog_pkg::OP_IDLE) begin
                s_nxt.ctl[5:0] = wbyte[5:0];
                s_nxt.win = 3'h0;
                if (wbyte[5:0] == {1'b0, flash_selfprog_pkg::CMD_REEN}) begin
                    o_nxt.valid = '0;
                end
            end
        end

        // store-program instruction
        if (store_ok && !s_r.ctl[flash_selfprog_pkg::BIT_SIGNATURE_READ_SELECT]) begin
            case (s_r.ctl[4:0])
                flash_selfprog_pkg::CMD_LOAD: begin
                    if (!o_r.valid[s_r.ptr[7:1]]) begin
                        buf_we = 1'b1;
                        o_nxt.valid[s_r.ptr[7:1]] = 1'b1;
                    end
                    s_nxt.ctl[flash_selfprog_pkg::BIT_BUSY] = 1'b0;
                    s_nxt.ctl[5:0] = 6'h0;
                end
                flash_selfprog_pkg::CMD_ERASE,
                flash_selfprog_pkg::CMD_WRITE: begin
                    o_nxt.page = s_r.ptr[15:8];
                    o_nxt.cnt = PROG_CYCLES[19:0];
                    s_nxt.ctl[5:0] = s_r.ctl[5:0];
                    if (s_r.ctl[4:0] == flash_selfprog_pkg::CMD_ERASE) begin
                        o_nxt.state = flash_selfprog_pkg::OP_ERASE;
                        o_nxt.erase_p = 1'b1;
                    end else begin
                        o_nxt.state = flash_selfprog_pkg::OP_WRITE;
                        o_nxt.write_p = 1'b1;
                    end
                    if (!in_halt(s_r.ptr[15:8])) begin
                        s_nxt.ctl[flash_selfprog_pkg::BIT_BUSY] = 1'b1;
                    end
                end
                flash_selfprog_pkg::CMD_LOCK: begin
                    o_nxt.state = flash_selfprog_pkg::OP_LOCK;
                    o_nxt.cnt = PROG_CYCLES[19:0];
                    s_nxt.ctl[5:0] = s_r.ctl[5:0];
                    o_nxt.lock_data = {s_r.data[5:2], 2'b11};
                end
                flash_selfprog_pkg::CMD_REEN: begin
                    s_nxt.ctl[flash_selfprog_pkg::BIT_BUSY] = 1'b0;
                    s_nxt.ctl[5:0] = 6'h0;
                end
                default: s_nxt.ctl[5:0] = 6'h0;
            endcase
        end else if (store_ok) begin
            s_nxt.ctl[5:0] = 6'h0; // store has no effect in signature mode
        end

        // load-program instruction: signature, fuse and lock readback
        if (load_rd) begin
            s_nxt.rdata = 32'h0;
            if (armed && s_r.win < flash_selfprog_pkg::LOAD_WINDOW) begin
                if (s_r.ctl[flash_selfprog_pkg::BIT_SIGNATURE_READ_SELECT]) begin
                    case (s_r.ptr)
                        flash_selfprog_pkg::PTR_SIG1: s_nxt.rdata[7:0] = SIG_BYTE1;
                        flash_selfprog_pkg::PTR_CAL: s_nxt.rdata[7:0] = osc_cal_byte;
                        flash_selfprog_pkg::PTR_SIG2: s_nxt.rdata[7:0] = SIG_BYTE2;
                        flash_selfprog_pkg::PTR_SIG3: s_nxt.rdata[7:0] = SIG_BYTE3;
                        default: s_nxt.rdata[7:0] = 8'h00;
                    endcase
                    s_nxt.ctl[5:0] = 6'h0;
                end else if (s_r.ctl[4:0] == flash_selfprog_pkg::CMD_LOCK
                    && !eeprom_write_busy) begin
                    case (s_r.ptr)
                        flash_selfprog_pkg::PTR_FUSE_LOW: s_nxt.rdata[7:0] = fuse_low_byte;
                        flash_selfprog_pkg::PTR_LOCK: s_nxt.rdata[7:0] = {2'b11, o_r.lock};
                        flash_selfprog_pkg::PTR_FUSE_EXT: s_nxt.rdata[7:0] = extended_fuse_byte;
                        flash_selfprog_pkg::PTR_FUSE_HIGH: s_nxt.rdata[7:0] = fuse_high_byte;
                        default: s_nxt.rdata[7:0] = 8'h00;
                    endcase
                    s_nxt.ctl[5:0] = 6'h0;
                end
            end
        end

        // eeprom write discards a partly loaded buffer
        if (eeprom_write_start && (|o_r.valid)) begin
            o_nxt.valid = '0;
        end

        // system reset clears the buffer once any running write is done
        if (s_r.rst_pending && o_r.state == flash_selfprog_pkg::OP_IDLE) begin
            o_nxt.valid = '0;
            s_nxt.rst_pending = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // system side, cleared by system reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{ctl: flash_selfprog_pkg::CTRL_RESET, win: 3'h0,
                ptr: flash_selfprog_pkg::PTR_RESET, data: flash_selfprog_pkg::DATA_RESET,
                ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00, rd_done: 1'b0,
                rdata: 32'h0, rst_pending: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // programming engine survives system reset, only power reset clears it
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            o_r <= '{state: flash_selfprog_pkg::OP_IDLE, cnt: 20'h0, page: 8'h00,
                lock_data: 6'h3f, lock: flash_selfprog_pkg::LOCK_RESET,
                valid: '0, erase_p: 1'b0, write_p: 1'b0};
        end else begin
            o_r <= o_nxt;
        end
    end

    // temporary page buffer storage
    always_ff @(posedge hclk) begin
        if (buf_we) begin
            buf_mem[buf_wa] <= s_r.data;
        end
    end

    // buffer readout toward the flash array, erased words read as ones
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            buf_rd_data <= flash_selfprog_pkg::ERASED_WORD;
        end else if (o_r.valid[buf_rd_word]) begin
            buf_rd_data <= buf_mem[buf_rd_word];
        end else begin
            buf_rd_data <= flash_selfprog_pkg::ERASED_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = !(s_r.ap_valid && !s_r.ap_write && !s_r.rd_done);
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign flash_erase_start = o_r.erase_p;
    assign flash_write_start = o_r.write_p;
    assign flash_page = o_r.page;
    assign section_busy_flag = s_r.ctl[flash_selfprog_pkg::BIT_BUSY];
    assign concurrent_read_block = s_r.ctl[flash_selfprog_pkg::BIT_BUSY];
    // erase and write to the halting section stall the cpu
    assign cpu_halt = (o_r.state == flash_selfprog_pkg::OP_ERASE
        || o_r.state == flash_selfprog_pkg::OP_WRITE) && in_halt(o_r.page);
    assign selfprog_irq = s_r.ctl[flash_selfprog_pkg::BIT_IE]
        && !s_r.ctl[flash_selfprog_pkg::BIT_STORE_EN];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_erase_launch: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (store_ok && !s_r.ctl[5] && s_r.ctl[4:0] == flash_selfprog_pkg::CMD_ERASE)
        |=> flash_erase_start && flash_page == $past(s_r.ptr[15:8]))
        else $error("erase did not launch on page field");

    a_window_expire: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (armed && s_r.win == 3'h3 && !store_ok && !ctrl_wr && !load_rd)
        |=> !s_r.ctl[flash_selfprog_pkg::BIT_STORE_EN])
        else $error("store enable outlived its window");

    a_halt_stall: assert property (@(posedge hclk) disable iff (!por_n)
        ((flash_write_start || flash_erase_start) && in_halt(flash_page))
        |-> cpu_halt ##1 cpu_halt)
        else $error("halting section write did not stall");

    a_busy_set: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (flash_erase_start && !in_halt(flash_page))
        |-> section_busy_flag && concurrent_read_block)
        else $error("section busy missing during erase");

    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (op_done && s_r.ctl[flash_selfprog_pkg::BIT_IE] && !ctrl_wr)
        |=> selfprog_irq ##1 (selfprog_irq || $past(ctrl_wr)))
        else $error("interrupt not raised after completion");

    a_eeprom_refuse: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (ctrl_wr && eeprom_write_busy && !armed && !op_done)
        |=> $stable(s_r.ctl[5:0]))
        else $error("command taken during eeprom write");

    a_buf_cleared: assert property (@(posedge hclk) disable iff (!por_n)
        (op_done && o_r.state == flash_selfprog_pkg::OP_WRITE) |=> o_r.valid == '0)
        else $error("buffer not cleared after page write");

    a_lock_program: assert property (@(posedge hclk) disable iff (!por_n)
        (op_done && o_r.state == flash_selfprog_pkg::OP_LOCK)
        |=> o_r.lock == ($past(o_r.lock) & $past(o_r.lock_data)))
        else $error("lock bits not programmed from data");

    a_bad_pattern: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
        (ctrl_wr && !is_cmd(wbyte) && !armed && !op_done && !load_rd)
        |=> $stable(s_r.ctl[5:0]))
        else $error("invalid pattern changed control");

endmodule

// >>> hdl/flash_selfprog_pkg.sv
package flash_selfprog_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PTR = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STORE = 8'h0c;
    localparam logic [7:0] ADDR_LOAD = 8'h10;

    // self_program_control bit positions
    localparam int BIT_STORE_EN = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_LOCK = 3;
    localparam int BIT_REEN = 4;
    localparam int BIT_SIGNATURE_READ_SELECT = 5;
    localparam int BIT_BUSY = 6;
    localparam int BIT_IE = 7;

    // low five bit command patterns
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;

    // command windows in clock cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;

    // first page of the halting section
    localparam logic [7:0] HALT_FIRST_PAGE = 8'he0;
    localparam int PAGE_WORDS = 128;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [5:0] LOCK_RESET = 6'h3f;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // readback pointers
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] PTR_SIG1 = 16'h0000;
    localparam logic [15:0] PTR_CAL = 16'h0001;
    localparam logic [15:0] PTR_SIG2 = 16'h0002;
    localparam logic [15:0] PTR_SIG3 = 16'h0004;

    // programming time, least figure, and its cycle count
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_NS = 3700000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // programming engine states
    typedef enum logic [3:0] {
        OP_IDLE = 4'b0001,
        OP_ERASE = 4'b0010,
        OP_WRITE = 4'b0100,
        OP_LOCK = 4'b1000
    } op_e;

endpackage

// >>> sim/cpu_model.sv
`timescale 1ns/100ps
// ahb-lite master standing in for the cpu core
module cpu_model (
    input wire logic hclk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata
);
    // bus idle at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic hclk, hresetn, por_n, ee_busy, ee_start, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] fl, fh, fe, pg, ld, sig[4];
    logic [6:0] bw, wd;
    logic [15:0] bd, dt;
    logic ers, wrt, busy, blk, halt, irq;
    int n_errors = 0, tests_run = 0, n_ers = 0, n_wrt = 0;
    ////////////////////////////////////////////////////////////////////////
    cpu_model u_cpu_model (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hready),
        .hrdata(hrdata));
    flash_selfprog #(.PROG_CYCLES(20), .SIG_BYTE1(8'ha5), .SIG_BYTE2(8'h96),
        .SIG_BYTE3(8'h0f)) u_flash_selfprog (.hclk(hclk), .hresetn(hresetn),
        .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hreadyin(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .eeprom_write_busy(ee_busy),
        .eeprom_write_start(ee_start), .fuse_low_byte(fl), .fuse_high_byte(fh),
        .extended_fuse_byte(fe), .osc_cal_byte(sig[1]), .buf_rd_word(bw),
        .buf_rd_data(bd), .flash_erase_start(ers), .flash_write_start(wrt),
        .flash_page(pg), .section_busy_flag(busy), .concurrent_read_block(blk),
        .cpu_halt(halt), .selfprog_irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // clock and pulse counters
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        n_ers += int'(ers);
        n_wrt += int'(wrt);
    end
    // bus shorthands and comparison
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_cpu_model.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        u_cpu_model.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // pointer, control pattern, then store at once
    task automatic cmd(input logic [15:0] p, input logic [7:0] c);
        wr(8'h04, {16'h0, p});
        wr(8'h00, {24'h0, c});
        wr(8'h0c, 32'h0);
    endtask
    // pointer, control pattern, then load at once
    task automatic ldr(input logic [15:0] p, input logic [7:0] c);
        wr(8'h04, {16'h0, p});
        wr(8'h00, {24'h0, c});
        rd(8'h10);
    endtask
    task automatic buf_is(input logic [6:0] w, input logic [15:0] e);
        bw <= w;
        repeat (2) @(posedge hclk);
        chk({16'h0, bd}, {16'h0, e});
    endtask
    task automatic end_of_test();
        $display("n_errors %0d tests_run %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0;
        por_n = 1'b0;
        ee_busy = 1'b0;
        ee_start = 1'b0;
        bw = 7'h0;
        sig = '{8'ha5, 8'h00, 8'h96, 8'h0f};
        void'($urandom(18578));
        {fl, fh, fe, sig[1]} = $urandom;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
        rd(8'h00);
        chk(q, 32'h0);
        buf_is(7'h0, 16'hffff);
        // fill before erase, random words at random addresses, one per quarter in ascending order
        for (int k = 0; k < 4; k++) begin
            wd = {k[1:0], 5'($urandom)};
            dt = 16'($urandom);
            wr(8'h08, {16'h0, dt});
            cmd({8'h0, wd, 1'b0}, 8'h01);
            rd(8'h00);
            chk(q[0], 1'b0);
            buf_is(wd, dt);
        end
        ld = 8'($urandom % 224);
        cmd({ld, 8'($urandom)}, 8'h83);
        repeat (2) @(posedge hclk);
        chk(n_ers, 1);
        chk({24'h0, pg}, {24'h0, ld});
        chk({busy, blk, halt, irq}, 4'b1100);
        rd(8'h00);
        chk(q[0], 1'b1);
        repeat (24) @(posedge hclk);
        chk(irq, 1'b1);
        cmd({ld, 8'h0}, 8'h05);
        repeat (2) @(posedge hclk);
        chk(n_wrt, 1);
        chk({24'h0, pg}, {24'h0, ld});
        chk({busy, halt}, 2'b10);
        repeat (24) @(posedge hclk);
        buf_is(wd, 16'hffff);
        cmd(16'h0, 8'h11);
        rd(8'h00);
        chk(q[6], 1'b0);
        // halting page erase survives a system reset
        cmd({3'h7, 5'($urandom), 8'h0}, 8'h03);
        repeat (2) @(posedge hclk);
        chk(halt, 1'b1);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(halt, 1'b1);
        repeat (30) @(posedge hclk);
        chk(halt, 1'b0);
        // unused patterns and an expired window
        for (int i = 0; i < 32; i++) begin
            if (!(i inside {1, 3, 5, 9, 17})) begin
                wr(8'h00, i);
                rd(8'h00);
                chk(q[5:0], 6'h0);
            end
        end
        wr(8'h00, 32'h1);
        repeat (6) @(posedge hclk);
        rd(8'h00);
        chk(q[0], 1'b0);
        // eeprom activity
        wr(8'h08, 32'h1234);
        cmd(16'h0, 8'h01);
        buf_is(7'h0, 16'h1234);
        ee_start <= 1'b1;
        @(posedge hclk);
        ee_start <= 1'b0;
        buf_is(7'h0, 16'hffff);
        ee_busy <= 1'b1;
        ldr(16'h0, 8'h09);
        chk(q, 32'h0);
        ee_busy <= 1'b0;
        @(posedge hclk);
        // fuse, lock and signature readback
        ldr(16'h0, 8'h09);
        chk(q, {24'h0, fl});
        ldr(16'h3, 8'h09);
        chk(q, {24'h0, fh});
        ldr(16'h2, 8'h09);
        chk(q, {24'h0, fe});
        dt = 16'($urandom);
        wr(8'h08, {16'h0, dt});
        cmd(16'h1, 8'h09);
        repeat (30) @(posedge hclk);
        ldr(16'h1, 8'h09);
        chk(q, {24'h0, 2'h3, dt[5:2], 2'h3});
        for (int i = 0; i < 4; i++) begin
            ldr(16'(i + (i == 3)), 8'h21);
            chk(q, {24'h0, sig[i]});
        end
        chk(hresp, 1'b0);
        end_of_test();
    end
endmodule
